/* File: core/bsr_pkg.sv */
// Purpose: shared constants and types for the buck setpoint range control
// Assumes: two buck channels, register index times four gives the byte address
// Notes:   millivolt figures are held at 12 bits, enough for the top code

package bsr_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_CH   = 2;
    localparam int NUM_MODE = 3;
    localparam int ADDR_W   = 9;
    localparam int IDX_W    = 7;
    localparam int CODE_W   = 6;
    localparam int MV_W     = 12;
    localparam int SYNC_W   = 3;

    // ==========================================================
    // register indexes, byte address = index * 4
    localparam logic [IDX_W-1:0] IDX_A_NORMAL  = 7'h3c;
    localparam logic [IDX_W-1:0] IDX_A_STANDBY = 7'h3d;
    localparam logic [IDX_W-1:0] IDX_A_SLEEP   = 7'h3e;
    localparam logic [IDX_W-1:0] IDX_B_NORMAL  = 7'h43;
    localparam logic [IDX_W-1:0] IDX_B_STANDBY = 7'h44;
    localparam logic [IDX_W-1:0] IDX_B_SLEEP   = 7'h45;
    localparam logic [IDX_W-1:0] IDX_STATUS    = 7'h48;
    localparam int               IDX_LSB       = 2;

    // ==========================================================
    // setpoint register layout and reset values
    localparam int               CODE_LSB     = 0;
    localparam int               RANGE_BIT    = 6;
    localparam int               UNUSED_BIT   = 7;
    localparam logic [CODE_W-1:0] CODE_RST    = 6'h00;
    localparam logic              RANGE_RST   = 1'h0;

    // ==========================================================
    // status register layout
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_RANGE_A  = 2;
    localparam int STAT_RANGE_B  = 3;
    localparam int STAT_LOW_A    = 4;
    localparam int STAT_LOW_B    = 5;
    localparam int STAT_OTP_DONE = 6;

    // ==========================================================
    // voltage decode in millivolts
    localparam logic [MV_W-1:0] LOW_BASE_MV   = 12'h190; // 400 mV
    localparam logic [MV_W-1:0] LOW_STEP_MV   = 12'h019; // 25 mV
    localparam logic [MV_W-1:0] HIGH_BASE_MV  = 12'h320; // 800 mV
    localparam logic [MV_W-1:0] HIGH_STEP_MV  = 12'h032; // 50 mV
    localparam logic [MV_W-1:0] MIN_OK_MV     = 12'h258; // 600 mV

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        BSR_MODE_NORMAL  = 2'b00,
        BSR_MODE_STANDBY = 2'b01,
        BSR_MODE_SLEEP   = 2'b10
    } bsr_mode_t;

    typedef enum logic {
        BSR_BUS_IDLE = 1'b0,
        BSR_BUS_ACK  = 1'b1
    } bsr_bus_t;

    typedef struct packed {
        logic              range_select_bit;
        logic [CODE_W-1:0] setpoint_code;
    } bsr_code_t;

    typedef struct packed {
        bsr_code_t       code;
        logic [MV_W-1:0] mv;
        logic            too_low;
    } bsr_target_t;

endpackage

/* File: core/bsr_setpoint_decode.sv */
// Purpose: picks the active setpoint of one channel and decodes it to millivolts
// Assumes: mode comes from logic on the same clock
// Notes:   outputs are registered, one cycle behind their inputs

`timescale 1ns/1ns

module bsr_setpoint_decode (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic [1:0]                   mode,
    input  wire logic [bsr_pkg::CODE_W-1:0]   normal_setpoint_code,
    input  wire logic [bsr_pkg::CODE_W-1:0]   standby_setpoint_code,
    input  wire logic [bsr_pkg::CODE_W-1:0]   sleep_setpoint_code,
    input  wire logic                         range_select_bit,
    output bsr_pkg::bsr_target_t              target
);

    // ==========================================================
    // decode
    bsr_pkg::bsr_target_t      target_d;
    bsr_pkg::bsr_target_t      target_q;
    logic [bsr_pkg::CODE_W-1:0] code_sel;
    logic [bsr_pkg::MV_W-1:0]   step_mul;

    // unused mode code 2'b11 falls back to normal as the safe choice
    always_comb begin
        case (mode)
            bsr_pkg::BSR_MODE_STANDBY: code_sel = standby_setpoint_code;
            bsr_pkg::BSR_MODE_SLEEP:   code_sel = sleep_setpoint_code;
            default:                   code_sel = normal_setpoint_code;
        endcase
        target_d.code.range_select_bit = range_select_bit;
        target_d.code.setpoint_code    = code_sel;
        if (range_select_bit) begin
            step_mul   = 12'(bsr_pkg::MV_W'(code_sel) * bsr_pkg::HIGH_STEP_MV);
            target_d.mv = 12'(bsr_pkg::HIGH_BASE_MV + step_mul);
        end else begin
            step_mul   = 12'(bsr_pkg::MV_W'(code_sel) * bsr_pkg::LOW_STEP_MV);
            target_d.mv = 12'(bsr_pkg::LOW_BASE_MV + step_mul);
        end
        // flagged only; the regulator itself is not stopped
        target_d.too_low = (target_d.mv <= bsr_pkg::MIN_OK_MV);
    end

    // output register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            target_q <= '0;
        end else begin
            target_q <= target_d;
        end
    end

    assign target = target_q;

endmodule

/* File: core/bsr_range_ctrl.sv */
// Purpose: setpoint registers, range bit capture and bus slave for two bucks
// Assumes: PWR_MODE is driven by power control logic on CLK_SYS
// Notes:   OTP_LOAD and OTP_RANGE come from outside and are synchronised
//          register map, byte address = index * 4:
//            channel a normal, standby, sleep at 0x0f0, 0x0f4, 0x0f8
//            channel b normal, standby, sleep at 0x10c, 0x110, 0x114
//            status at 0x120, read-only
//          setpoint layout: [5:0] code, [6] range (read-only), [7] zero
//          status layout: [1:0] mode, [2] range a, [3] range b,
//            [4] too low a, [5] too low b, [6] range captured
//          status range and too-low bits lag the target by one cycle
//          every access costs one wait cycle; unmapped reads return zero
//          writes with byte lane 0 off, or to the status word, are dropped
//          range source: DEFAULT_RANGE at reset, then one capture per reset
//          the range never moves on a live rail once that capture is done
//          too-low is a flag only; the rail is not clamped or stopped
//
// Local design decisions: the address map and register access over Avalon-MM.

`timescale 1ns/1ns

module bsr_range_ctrl #(
    parameter logic [bsr_pkg::NUM_CH-1:0] DEFAULT_RANGE = 2'h0
) (
    input  wire logic                          CLK_SYS,
    input  wire logic                          RESET_N,
    input  wire logic [bsr_pkg::ADDR_W-1:0]    AVS_ADDRESS,
    input  wire logic                          AVS_READ,
    input  wire logic                          AVS_WRITE,
    input  wire logic [31:0]                   AVS_WRITEDATA,
    input  wire logic [3:0]                    AVS_BYTEENABLE,
    output      logic [31:0]                   AVS_READDATA,
    output      logic                          AVS_WAITREQUEST,
    input  wire logic                          OTP_LOAD,
    input  wire logic [bsr_pkg::NUM_CH-1:0]    OTP_RANGE,
    input  wire logic [1:0]                    PWR_MODE,
    output bsr_pkg::bsr_target_t [bsr_pkg::NUM_CH-1:0] TARGET
);

    // ==========================================================
    // input synchronisers
    logic [bsr_pkg::SYNC_W-1:0]                  load_sync_q;
    logic [bsr_pkg::SYNC_W-1:0]                  load_sync_d;
    logic [bsr_pkg::SYNC_W-1:0][bsr_pkg::NUM_CH-1:0] rng_sync_q;
    logic [bsr_pkg::SYNC_W-1:0][bsr_pkg::NUM_CH-1:0] rng_sync_d;
    logic                                        load_stable;
    logic                                        rng_stable;

    // shift one stage per clock; first stage feeds only the second
    always_comb begin
        load_sync_d = {load_sync_q[bsr_pkg::SYNC_W-2:0], OTP_LOAD};
        rng_sync_d  = {rng_sync_q[bsr_pkg::SYNC_W-2:0], OTP_RANGE};
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            load_sync_q <= '0;
            rng_sync_q  <= '0;
        end else begin
            load_sync_q <= load_sync_d;
            rng_sync_q  <= rng_sync_d;
        end
    end

    // a level counts only once stages two and three agree
    assign load_stable = load_sync_q[1] & load_sync_q[2];
    assign rng_stable  = (rng_sync_q[1] == rng_sync_q[2]);

    // ==========================================================
    // range bit capture
    logic [bsr_pkg::NUM_CH-1:0]                  rng_q [bsr_pkg::NUM_MODE];
    logic [bsr_pkg::NUM_CH-1:0]                  rng_d [bsr_pkg::NUM_MODE];
    logic                                        otp_done_q;
    logic                                        otp_done_d;

    // taken once per reset: later OTP pulses cannot move a live rail's range
    always_comb begin
        rng_d      = rng_q;
        otp_done_d = otp_done_q;
        if (!otp_done_q && load_stable && rng_stable) begin
            for (int m = 0; m < bsr_pkg::NUM_MODE; m++) begin
                rng_d[m] = rng_sync_q[2];
            end
            otp_done_d = 1'b1;
        end
    end

    // default range at reset, same value in all three mode registers
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            for (int m = 0; m < bsr_pkg::NUM_MODE; m++) begin
                rng_q[m] <= DEFAULT_RANGE;
            end
            otp_done_q <= 1'b0;
        end else begin
            rng_q      <= rng_d;
            otp_done_q <= otp_done_d;
        end
    end

    // ==========================================================
    // address decode
    logic                                        hit_sp;
    logic                                        hit_stat;
    logic                                        ch_sel;
    logic [1:0]                                  md_sel;
    logic [bsr_pkg::IDX_W-1:0]                   idx;

    assign idx = AVS_ADDRESS[bsr_pkg::ADDR_W-1:bsr_pkg::IDX_LSB];

    // misaligned byte addresses fall through as unmapped
    always_comb begin
        hit_sp   = 1'b0;
        hit_stat = 1'b0;
        ch_sel   = 1'b0;
        md_sel   = bsr_pkg::BSR_MODE_NORMAL;
        if (AVS_ADDRESS[bsr_pkg::IDX_LSB-1:0] != 2'h0) begin
            hit_sp = 1'b0;
        end else if (idx == bsr_pkg::IDX_A_NORMAL) begin
            hit_sp = 1'b1;
        end else if (idx == bsr_pkg::IDX_A_STANDBY) begin
            hit_sp = 1'b1;
            md_sel = bsr_pkg::BSR_MODE_STANDBY;
        end else if (idx == bsr_pkg::IDX_A_SLEEP) begin
            hit_sp = 1'b1;
            md_sel = bsr_pkg::BSR_MODE_SLEEP;
        end else if (idx == bsr_pkg::IDX_B_NORMAL) begin
            hit_sp = 1'b1;
            ch_sel = 1'b1;
        end else if (idx == bsr_pkg::IDX_B_STANDBY) begin
            hit_sp = 1'b1;
            ch_sel = 1'b1;
            md_sel = bsr_pkg::BSR_MODE_STANDBY;
        end else if (idx == bsr_pkg::IDX_B_SLEEP) begin
            hit_sp = 1'b1;
            ch_sel = 1'b1;
            md_sel = bsr_pkg::BSR_MODE_SLEEP;
        end else if (idx == bsr_pkg::IDX_STATUS) begin
            hit_stat = 1'b1;
        end
    end

    // ==========================================================
    // bus handshake: one wait cycle on every access
    // setpoint store sits here because the read path below already uses it
    logic [bsr_pkg::CODE_W-1:0]                  sp_q [bsr_pkg::NUM_CH][bsr_pkg::NUM_MODE];
    logic [bsr_pkg::CODE_W-1:0]                  sp_d [bsr_pkg::NUM_CH][bsr_pkg::NUM_MODE];
    bsr_pkg::bsr_bus_t                           bus_q;
    bsr_pkg::bsr_bus_t                           bus_d;
    logic [31:0]                                 rdata_q;
    logic [31:0]                                 rdata_d;
    logic                                        req;
    logic                                        wr_take;

    assign req     = AVS_READ | AVS_WRITE;
    // write lands on the edge where waitrequest is low
    assign wr_take = AVS_WRITE && (bus_q == bsr_pkg::BSR_BUS_ACK);

    // read data is built in the wait cycle so it stands when released
    always_comb begin
        bus_d   = bus_q;
        rdata_d = rdata_q;
        case (bus_q)
            bsr_pkg::BSR_BUS_IDLE: begin
                if (req) begin
                    bus_d   = bsr_pkg::BSR_BUS_ACK;
                    rdata_d = '0; // unmapped reads return zero
                    if (AVS_READ && hit_sp) begin
                        rdata_d[bsr_pkg::CODE_LSB +: bsr_pkg::CODE_W] =
                            sp_q[ch_sel][md_sel];
                        rdata_d[bsr_pkg::RANGE_BIT]  = rng_q[md_sel][ch_sel];
                        rdata_d[bsr_pkg::UNUSED_BIT] = 1'b0;
                    end else if (AVS_READ && hit_stat) begin
                        rdata_d[bsr_pkg::STAT_MODE_LSB +: 2] = PWR_MODE;
                        rdata_d[bsr_pkg::STAT_RANGE_A]  = TARGET[0].code.range_select_bit;
                        rdata_d[bsr_pkg::STAT_RANGE_B]  = TARGET[1].code.range_select_bit;
                        rdata_d[bsr_pkg::STAT_LOW_A]    = TARGET[0].too_low;
                        rdata_d[bsr_pkg::STAT_LOW_B]    = TARGET[1].too_low;
                        rdata_d[bsr_pkg::STAT_OTP_DONE] = otp_done_q;
                    end
                end
            end
            bsr_pkg::BSR_BUS_ACK: begin
                bus_d = bsr_pkg::BSR_BUS_IDLE;
            end
            default: begin
                bus_d = bsr_pkg::BSR_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            bus_q   <= bsr_pkg::BSR_BUS_IDLE;
            rdata_q <= '0;
        end else begin
            bus_q   <= bus_d;
            rdata_q <= rdata_d;
        end
    end

    assign AVS_WAITREQUEST = req && (bus_q != bsr_pkg::BSR_BUS_ACK);
    assign AVS_READDATA    = rdata_q;

    // ==========================================================
    // setpoint registers
    // six codes, one per channel and mode; the range bits live apart

    // only the low six bits take write data; bits 6 and 7 are dropped
    always_comb begin
        sp_d = sp_q;
        if (wr_take && hit_sp && AVS_BYTEENABLE[0]) begin
            sp_d[ch_sel][md_sel] =
                AVS_WRITEDATA[bsr_pkg::CODE_LSB +: bsr_pkg::CODE_W];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            for (int c = 0; c < bsr_pkg::NUM_CH; c++) begin
                for (int m = 0; m < bsr_pkg::NUM_MODE; m++) begin
                    sp_q[c][m] <= bsr_pkg::CODE_RST;
                end
            end
        end else begin
            sp_q <= sp_d;
        end
    end

    // ==========================================================
    // per channel decode to the regulator
    // no cross-channel tie: single-phase setups rely on software
    // programming both channels alike, channel a then in control
    genvar g;
    generate
        for (g = 0; g < bsr_pkg::NUM_CH; g++) begin : g_ch
            bsr_setpoint_decode u_dec (
                .clk                   (CLK_SYS),
                .rst_n                 (RESET_N),
                .mode                  (PWR_MODE),
                .normal_setpoint_code  (sp_q[g][bsr_pkg::BSR_MODE_NORMAL]),
                .standby_setpoint_code (sp_q[g][bsr_pkg::BSR_MODE_STANDBY]),
                .sleep_setpoint_code   (sp_q[g][bsr_pkg::BSR_MODE_SLEEP]),
                .range_select_bit      (rng_q[bsr_pkg::BSR_MODE_NORMAL][g]),
                .target                (TARGET[g])
            );
        end
    endgenerate

endmodule

/* File: tb/bsr_range_ctrl_sva.sv */
// Purpose: bus and decode checks on the buck setpoint range control ports
// Assumes: one clock domain, synchronous active-low reset
// Notes:   decode checks wait three edges after reset for the target to settle

`timescale 1ns/1ns

module bsr_range_ctrl_chk #(
    parameter logic [bsr_pkg::NUM_CH-1:0] DEFAULT_RANGE = 2'h0
) (
    input wire logic                                    CLK_SYS,
    input wire logic                                    RESET_N,
    input wire logic [bsr_pkg::ADDR_W-1:0]              AVS_ADDRESS,
    input wire logic                                    AVS_READ,
    input wire logic                                    AVS_WRITE,
    input wire logic [31:0]                             AVS_READDATA,
    input wire logic                                    AVS_WAITREQUEST,
    input wire logic                                    OTP_LOAD,
    input wire logic [1:0]                              PWR_MODE,
    input wire bsr_pkg::bsr_target_t [bsr_pkg::NUM_CH-1:0] TARGET
);
    logic [1:0] up_q;
    logic [1:0] up_d;
    logic       ok;
    logic [1:0] rng;

    // =========================================================
    // settle counter: target is all zero for a cycle after reset
    always_comb begin
        up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
    end
    always_ff @(posedge CLK_SYS) begin
        up_q <= RESET_N ? up_d : 2'h0;
    end
    assign ok  = (up_q == 2'h3);
    assign rng = {TARGET[1].code.range_select_bit, TARGET[0].code.range_select_bit};

    function automatic logic mapped(input logic [8:0] a);
        return a[1:0] == 2'h0 && (a[8:2] inside {7'h3c, 7'h3d, 7'h3e, 7'h43, 7'h44, 7'h45, 7'h48});
    endfunction

    // =========================================================
    // properties
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    sequence s_wait_one;
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endsequence
    sequence s_quiet_otp;
        (ok && !OTP_LOAD) [*5];
    endsequence
    property p_dec(logic r, logic [5:0] c, logic [11:0] mv);
        ok |-> mv == (r ? bsr_pkg::HIGH_BASE_MV + bsr_pkg::HIGH_STEP_MV * c
                        : bsr_pkg::LOW_BASE_MV + bsr_pkg::LOW_STEP_MV * c);
    endproperty

    chk_wait_once: assert property ($rose(AVS_READ || AVS_WRITE) |-> s_wait_one)
        else $error("request not answered after exactly one wait cycle");
    chk_idle_nowait: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
        else $error("waitrequest high with no request");
    chk_upper_zero: assert property (AVS_READDATA[31:7] == 25'h0)
        else $error("read data above bit 6 not zero");
    chk_unmapped_zero: assert property (
        AVS_READ && AVS_WAITREQUEST && !mapped(AVS_ADDRESS) |=> AVS_READDATA == 32'h0)
        else $error("unmapped read returned data");
    chk_dec_a: assert property (
        p_dec(TARGET[0].code.range_select_bit, TARGET[0].code.setpoint_code, TARGET[0].mv))
        else $error("channel a millivolts wrong");
    chk_dec_b: assert property (
        p_dec(TARGET[1].code.range_select_bit, TARGET[1].code.setpoint_code, TARGET[1].mv))
        else $error("channel b millivolts wrong");
    chk_too_low_flag: assert property (
        ok |-> TARGET[0].too_low == (TARGET[0].mv <= 12'h258)
        && TARGET[1].too_low == (TARGET[1].mv <= 12'h258))
        else $error("too low flag wrong");
    chk_range_hold: assert property (s_quiet_otp |-> $stable(rng))
        else $error("range bit moved without a capture");
    chk_write_range: assert property (
        s_quiet_otp ##0 (AVS_WRITE && !AVS_WAITREQUEST) |=> ##1 $stable(rng))
        else $error("write changed a range bit");
endmodule

bind bsr_range_ctrl bsr_range_ctrl_chk #(.DEFAULT_RANGE(DEFAULT_RANGE)) u_chk (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .OTP_LOAD(OTP_LOAD), .PWR_MODE(PWR_MODE), .TARGET(TARGET));

/* File: tb/bsr_range_ctrl_tb.sv */
// Purpose: self-checking bench for the buck setpoint range control
// Assumes: Avalon master with one request at a time
// Notes:   bus answers taken at the rising edge, other outputs on the falling edge

`timescale 1ns/1ns

module bsr_range_ctrl_tb;
    typedef struct packed {
        logic [6:0]  idx;
        logic [1:0]  mode;
        logic [7:0]  wd;
        logic [11:0] mv;
        logic        lo;
    } bsr_row_t;

    logic        CLK_SYS = 1'b0;
    logic        RESET_N = 1'b0;
    logic [8:0]  AVS_ADDRESS = 9'h000;
    logic        AVS_READ = 1'b0;
    logic        AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0]  AVS_BYTEENABLE = 4'hf;
    logic [31:0] AVS_READDATA;
    logic        AVS_WAITREQUEST;
    logic        OTP_LOAD = 1'b0;
    logic [1:0]  OTP_RANGE = 2'h0;
    logic [1:0]  PWR_MODE = 2'h0;
    bsr_pkg::bsr_target_t [1:0] TARGET;
    int          mismatches = 0;
    int          checks = 0;
    int          cycles = 0;
    logic [31:0] d;
    bsr_row_t    rows [6] = '{
        '{7'h3c, 2'h0, 8'hff, 12'h7b7, 1'b0}, '{7'h3d, 2'h1, 8'h08, 12'h258, 1'b1},
        '{7'h3e, 2'h2, 8'h49, 12'h271, 1'b0}, '{7'h43, 2'h3, 8'h80, 12'h190, 1'b1},
        '{7'h44, 2'h1, 8'h2a, 12'h5aa, 1'b0}, '{7'h45, 2'h2, 8'h15, 12'h39d, 1'b0}};

    bsr_range_ctrl uut (
        .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .OTP_LOAD(OTP_LOAD),
        .OTP_RANGE(OTP_RANGE), .PWR_MODE(PWR_MODE), .TARGET(TARGET));

    // =========================================================
    // clock and hang guard; tests need about 115 cycles
    always #4 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            close_out();
        end
    end

    // =========================================================
    // helpers
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one Avalon access; holds everything until waitrequest is seen low
    task automatic bus(input logic wr, input logic [8:0] a, input logic [7:0] wd,
                       input logic [3:0] be, output logic [31:0] rd);
        @(posedge CLK_SYS);
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= {24'h0, wd};
        AVS_BYTEENABLE <= be;
        // waitrequest and read data are the values sampled at this rising edge
        do begin
            @(posedge CLK_SYS);
        end while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask

    function automatic logic [11:0] exp_mv(input logic r, input logic [5:0] c);
        return r ? bsr_pkg::HIGH_BASE_MV + bsr_pkg::HIGH_STEP_MV * c
                 : bsr_pkg::LOW_BASE_MV + bsr_pkg::LOW_STEP_MV * c;
    endfunction

    // =========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge CLK_SYS);
        RESET_N <= 1'b1;
        // table rows: write a setpoint, select its mode, check target and readback
        foreach (rows[i]) begin
            bus(1'b1, {rows[i].idx, 2'h0}, rows[i].wd, 4'hf, d);
            PWR_MODE <= rows[i].mode;
            repeat (3) @(posedge CLK_SYS);
            @(negedge CLK_SYS);
            chk(TARGET[rows[i].idx > 7'h3e].mv, rows[i].mv);
            chk(TARGET[rows[i].idx > 7'h3e].too_low, rows[i].lo);
            chk(TARGET[rows[i].idx > 7'h3e].code, {1'b0, rows[i].wd[5:0]});
            bus(1'b0, {rows[i].idx, 2'h0}, 8'h00, 4'hf, d);
            chk(d, {26'h0, rows[i].wd[5:0]});
            $display("row %0d done", i);
        end
        // refused writes and unmapped reads
        bus(1'b1, 9'h0f0, 8'h05, 4'he, d);
        bus(1'b0, 9'h0f0, 8'h00, 4'hf, d);
        chk(d, 32'h3f);
        bus(1'b1, 9'h0f0, 8'hc1, 4'hf, d);
        bus(1'b0, 9'h0f0, 8'h00, 4'hf, d);
        chk(d, 32'h01);
        bus(1'b0, 9'h0fc, 8'h00, 4'hf, d);
        chk(d, 32'h0);
        bus(1'b0, 9'h0f2, 8'h00, 4'hf, d);
        chk(d, 32'h0);
        bus(1'b0, 9'h120, 8'h00, 4'hf, d);
        chk(d, 32'h02);
        $display("refusal test done");
        // one-time range capture for channel a only
        OTP_RANGE <= 2'h1;
        OTP_LOAD <= 1'b1;
        repeat (8) @(posedge CLK_SYS);
        bus(1'b0, 9'h0f4, 8'h00, 4'hf, d);
        chk(d, 32'h48);
        bus(1'b0, 9'h0f8, 8'h00, 4'hf, d);
        chk(d, 32'h49);
        bus(1'b0, 9'h10c, 8'h00, 4'hf, d);
        chk(d, 32'h00);
        bus(1'b0, 9'h120, 8'h00, 4'hf, d);
        chk(d, 32'h46);
        @(negedge CLK_SYS);
        chk(TARGET[0].mv, exp_mv(1'b1, 6'h09));
        chk(TARGET[0].code.range_select_bit, 1'b1);
        $display("capture test done");
        // second reset returns setpoints and range to their defaults
        @(posedge CLK_SYS);
        OTP_LOAD <= 1'b0;
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        RESET_N <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        bus(1'b0, 9'h0f0, 8'h00, 4'hf, d);
        chk(d, 32'h0);
        @(negedge CLK_SYS);
        chk(TARGET[0].mv, exp_mv(1'b0, 6'h00));
        $display("reset test done");
        // single phase: both channels get the same low-range setpoint
        bus(1'b1, 9'h0f0, 8'h20, 4'hf, d);
        bus(1'b1, 9'h10c, 8'h20, 4'hf, d);
        PWR_MODE <= 2'h0;
        repeat (2) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        chk(TARGET[0].mv, exp_mv(1'b0, 6'h20));
        chk(TARGET[1].mv, exp_mv(1'b0, 6'h20));
        chk(TARGET[1].code, {1'b0, 6'h20});
        $display("single phase test done");
        close_out();
    end
endmodule
